// *** hw/dsct_pkg.sv ***
// Purpose: shared constants and types for the dual split/capture timer block
// Assumes: registers sit on the core's 8-bit special-function-register port
// Notes:   two printed offsets collide; each has an alias address named _ALT
package dsct_pkg;

   // register addresses on the special-function-register port
   localparam logic [7:0] ADDR_T3_CONTROL     = 8'hb9;
   localparam logic [7:0] ADDR_T3_RELOAD_LOW  = 8'hba;
   localparam logic [7:0] ADDR_T3_RELOAD_HIGH = 8'hbb;
   localparam logic [7:0] ADDR_T3_COUNT_LOW   = 8'hbc;
   localparam logic [7:0] ADDR_T3_COUNT_HIGH  = 8'hbc;
   localparam logic [7:0] ADDR_T3_COUNT_H_ALT = 8'hbd;
   localparam logic [7:0] ADDR_T2_CONTROL     = 8'hc8;
   localparam logic [7:0] ADDR_CLOCK_SELECT   = 8'hc9;
   localparam logic [7:0] ADDR_T2_RELOAD_LOW  = 8'hca;
   localparam logic [7:0] ADDR_T2_RELOAD_HIGH = 8'hca;
   localparam logic [7:0] ADDR_T2_RELOAD_H_ALT = 8'hcb;
   localparam logic [7:0] ADDR_T2_COUNT_LOW   = 8'hcc;
   localparam logic [7:0] ADDR_T2_COUNT_HIGH  = 8'hcd;

   // reset value and byte constants
   localparam logic [7:0] RESET_BYTE          = 8'h00;
   localparam logic [7:0] BYTE_ALL_ONES       = 8'hff;
   localparam logic [7:0] BYTE_ONE            = 8'h01;

   // time base: clock and tick periods in picoseconds, divider and tick lengths in mclk cycles
   localparam int unsigned CLK_PERIOD_PS      = 25000;
   localparam int unsigned TICK_A_PS          = 5120000;
   localparam int unsigned TICK_B_PS          = 100000000;
   localparam int unsigned DIV_SYS            = 12;
   localparam int unsigned TICK_A_CYCLES      = TICK_A_PS / CLK_PERIOD_PS;
   localparam int unsigned TICK_B_CYCLES      = TICK_B_PS / CLK_PERIOD_PS;

   // count clock source code, same for all four halves
   typedef enum logic [1:0] {
      SRC_SYS,
      SRC_DIV12,
      SRC_TICK_A,
      SRC_TICK_B
   } dsct_clksrc_t;

   // per-timer control register layout, bit 7 first
   typedef struct packed {
      logic upper_event_flag;
      logic lower_event_flag;
      logic lower_irq_enable;
      logic split_select;
      logic upper_capture_select;
      logic lower_capture_select;
      logic upper_run;
      logic lower_run;
   } dsct_ctrl_t;

   // clock select register layout, bit 7 first
   typedef struct packed {
      dsct_clksrc_t t3_hi;
      dsct_clksrc_t t3_lo;
      dsct_clksrc_t t2_hi;
      dsct_clksrc_t t2_lo;
   } dsct_cksel_t;

   // write strobes for one timer
   typedef struct packed {
      logic ctrl;
      logic reload_lo;
      logic reload_hi;
      logic count_lo;
      logic count_hi;
   } dsct_wr_t;

endpackage : dsct_pkg

// *** hw/dsct_timers.sv ***
// Purpose: two 16-bit timers, each wide or split into two 8-bit halves,
//          each half in reload or capture mode, with sticky flags and irq
// Assumes: mclk at 40 MHz, srst synchronous active high, sfr port sampled
// Notes:   read data is registered, one cycle after the address
//
// Functional notes
// - reload/capture bytes are not double buffered; a write takes effect at once.
// - in capture mode the reload/capture register holds the captured count.
// - in timer mode the reload/capture register is the value reloaded on overflow.
// - high flag bit 7 sets on high overflow or high capture; wide means whole timer, overflow only in timer mode.
// - low flag bit 6 sets on low overflow in timer mode or low capture when split.
// - hardware never clears the flags; software clears them.
// - in wide timer mode the low flag still sets on low byte overflow.
// - wide capture mode sets the low flag on high byte overflow, a 17th bit.
// - wide capture mode: a capture sets only the high flag.
// - irq is high flag OR (low flag AND low irq enable bit 5).
// - split bit 4 clear: one 16-bit timer driven by the low-half controls.
// - split bit set: both halves run and are controlled independently.
// - high capture bit 3 selects capture for high half; ignored when wide.
// - low capture bit 2 selects capture for low half, or whole timer when wide.
// - high run bit 1 enables the high half when split; no effect when wide.
// - low run bit 0 enables the low half when split, whole timer when wide.
// - live count is readable and writable as low and high bytes.
// - each half picks its clock when split (wide runs on the low pick): sys, sys/12, 5.1us tick (204 cycles) or 100us tick.
`timescale 1ns/1ps

// free-running pulse generator, one mclk-wide pulse every PERIOD cycles
module dsct_pulse #(
   parameter int unsigned PERIOD = 12
) (
   input  wire logic mclk,
   input  wire logic srst,
   output logic      pulse
);
   logic [11:0] cnt_q;
   logic [11:0] cnt_d;
   logic        pulse_d;
   wire         wrap = (cnt_q == 12'(PERIOD - 1));

   // counter wraps at the period; pulse is registered so it is glitch free
   assign cnt_d   = wrap ? '0 : cnt_q + 12'h001;
   assign pulse_d = wrap;

   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt_q <= '0;
         pulse <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pulse <= pulse_d;
      end
   end
endmodule : dsct_pulse

// one timer: control, reload/capture pair and count pair
module dsct_timer (
   input  wire logic                  mclk,
   input  wire logic                  srst,
   input  wire dsct_pkg::dsct_wr_t    wr,
   input  wire logic [7:0]            wdata,
   input  wire logic [3:0]            ticks,
   input  wire dsct_pkg::dsct_clksrc_t src_lo,
   input  wire dsct_pkg::dsct_clksrc_t src_hi,
   input  wire logic                  cap_lo_evt,
   input  wire logic                  cap_hi_evt,
   output dsct_pkg::dsct_ctrl_t       ctrl,
   output logic [7:0]                 reload_lo,
   output logic [7:0]                 reload_hi,
   output logic [7:0]                 count_lo,
   output logic [7:0]                 count_hi,
   output logic                       irq
);
   dsct_pkg::dsct_ctrl_t ctrl_q;
   dsct_pkg::dsct_ctrl_t ctrl_d;
   dsct_pkg::dsct_ctrl_t ctrl_wr;
   logic [7:0]           rl_q, rl_d;
   logic [7:0]           rh_q, rh_d;
   logic [7:0]           cl_q, cl_d;
   logic [7:0]           ch_q, ch_d;

   // configuration decode: wide mode hands both halves to the low controls
   wire wide        = ~ctrl_q.split_select;
   wire cap_lo_mode = ctrl_q.lower_capture_select;
   wire cap_hi_mode = wide ? cap_lo_mode : ctrl_q.upper_capture_select;
   wire tick_lo     = ticks[src_lo];
   wire tick_hi     = ticks[src_hi];
   wire lo_full     = (cl_q == dsct_pkg::BYTE_ALL_ONES);
   wire hi_full     = (ch_q == dsct_pkg::BYTE_ALL_ONES);

   // count enables; in wide mode the high byte steps on the low byte carry
   wire run_lo = ctrl_q.lower_run & tick_lo;
   wire run_hi = wide ? (run_lo & lo_full)
                      : (ctrl_q.upper_run & tick_hi);
   wire lo_ovf = run_lo & lo_full;
   wire hi_ovf = run_hi & hi_full;

   // reload on overflow in timer mode; wide reload only on the 16-bit wrap
   wire ld_lo = lo_ovf & ~cap_lo_mode & (~wide | hi_ovf);
   wire ld_hi = hi_ovf & ~cap_hi_mode;

   // capture events; wide mode shares the low-half event for both bytes
   wire take_lo = cap_lo_mode & cap_lo_evt;
   wire take_hi = wide ? take_lo : (cap_hi_mode & cap_hi_evt);

   // flag set terms
   wire set_hi = take_hi | (hi_ovf & ~(wide & cap_lo_mode));
   wire set_lo = wide ? (cap_lo_mode ? hi_ovf : lo_ovf)
                      : (cap_lo_mode ? take_lo : lo_ovf);

   // software write first, then hardware set on top so no event is lost
   assign ctrl_wr = dsct_pkg::dsct_ctrl_t'(wdata);
   always_comb begin
      ctrl_d = wr.ctrl ? ctrl_wr : ctrl_q;
      ctrl_d.upper_event_flag = ctrl_d.upper_event_flag | set_hi;
      ctrl_d.lower_event_flag = ctrl_d.lower_event_flag | set_lo;
   end

   // capture beats a same-cycle software write, the event is the rarer one
   assign rl_d = take_lo ? cl_q : (wr.reload_lo ? wdata : rl_q);
   assign rh_d = take_hi ? ch_q : (wr.reload_hi ? wdata : rh_q);

   // software count write wins over counting in the same cycle
   assign cl_d = wr.count_lo ? wdata :
                 ld_lo       ? rl_q  :
                 run_lo      ? cl_q + dsct_pkg::BYTE_ONE : cl_q;
   assign ch_d = wr.count_hi ? wdata :
                 ld_hi       ? rh_q  :
                 run_hi      ? ch_q + dsct_pkg::BYTE_ONE : ch_q;

   // interrupt request, a level from the flag registers
   assign irq = ctrl_q.upper_event_flag
              | (ctrl_q.lower_event_flag & ctrl_q.lower_irq_enable);

   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl_q <= dsct_pkg::dsct_ctrl_t'(dsct_pkg::RESET_BYTE);
         rl_q   <= dsct_pkg::RESET_BYTE;
         rh_q   <= dsct_pkg::RESET_BYTE;
         cl_q   <= dsct_pkg::RESET_BYTE;
         ch_q   <= dsct_pkg::RESET_BYTE;
      end else begin
         ctrl_q <= ctrl_d;
         rl_q   <= rl_d;
         rh_q   <= rh_d;
         cl_q   <= cl_d;
         ch_q   <= ch_d;
      end
   end

   assign ctrl      = ctrl_q;
   assign reload_lo = rl_q;
   assign reload_hi = rh_q;
   assign count_lo  = cl_q;
   assign count_hi  = ch_q;

   // a set flag stays set until software writes the control register
   a_flag_sticky_hi: assert property (@(posedge mclk) disable iff (srst)
      ctrl_q.upper_event_flag && !wr.ctrl |=> ctrl_q.upper_event_flag)
      else $error("high flag dropped without a control write");

   a_flag_sticky_lo: assert property (@(posedge mclk) disable iff (srst)
      ctrl_q.lower_event_flag && !wr.ctrl |=> ctrl_q.lower_event_flag)
      else $error("low flag dropped without a control write");

   // a fresh high flag, or a low flag with its enable, raises the request next cycle
   a_irq_request: assert property (@(posedge mclk) disable iff (srst)
      set_hi || (set_lo && ctrl_d.lower_irq_enable)
      |=> irq)
      else $error("irq missing after a flag set");

   // wide timer-mode wrap reloads both bytes from the reload pair
   a_wide_reload: assert property (@(posedge mclk) disable iff (srst)
      !ctrl_q.split_select && ctrl_q.lower_run && tick_lo && !cap_lo_mode
      && lo_full && hi_full && !wr.count_lo && !wr.count_hi
      |=> {ch_q, cl_q} == $past({rh_q, rl_q}))
      else $error("wide overflow did not reload the count");

   // split high-half capture stores the high count
   a_capture_hi: assert property (@(posedge mclk) disable iff (srst)
      ctrl_q.split_select && ctrl_q.upper_capture_select && cap_hi_evt
      |=> rh_q == $past(ch_q))
      else $error("high capture did not store the count");

   // wide capture: only the high flag, low flag untouched without overflow
   a_wide_cap_hi: assert property (@(posedge mclk) disable iff (srst)
      !ctrl_q.split_select && cap_lo_mode && cap_lo_evt && !hi_ovf
      && !ctrl_q.lower_event_flag && !wr.ctrl
      |=> ctrl_q.upper_event_flag && !ctrl_q.lower_event_flag)
      else $error("wide capture touched the low flag");

   // wide capture overflow becomes the seventeenth bit
   a_wide_cap17: assert property (@(posedge mclk) disable iff (srst)
      !ctrl_q.split_select && cap_lo_mode && ctrl_q.lower_run && tick_lo
      && lo_full && hi_full
      |=> ctrl_q.lower_event_flag)
      else $error("wide capture overflow missed the low flag");

   // wide timer mode low byte carry still sets the low flag
   a_wide_lo_flag: assert property (@(posedge mclk) disable iff (srst)
      !ctrl_q.split_select && !cap_lo_mode && ctrl_q.lower_run && tick_lo
      && lo_full
      |=> ctrl_q.lower_event_flag)
      else $error("low byte carry missed the low flag");

   // wide mode with low run clear: the count holds, whatever the high run says
   a_wide_hold: assert property (@(posedge mclk) disable iff (srst)
      !ctrl_q.split_select && !ctrl_q.lower_run && !wr.count_lo && !wr.count_hi
      |=> $stable(cl_q) && $stable(ch_q))
      else $error("stopped wide timer moved");

   // a reload byte write lands in the next cycle
   a_reload_write: assert property (@(posedge mclk) disable iff (srst)
      wr.reload_lo && !take_lo |=> rl_q == $past(wdata))
      else $error("reload low write did not take effect");

endmodule : dsct_timer

// top: special-function-register port, tick generation and two timers
module dsct_timers (
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic       t2_cap_lo_evt,
   input  wire logic       t2_cap_hi_evt,
   input  wire logic       t3_cap_lo_evt,
   input  wire logic       t3_cap_hi_evt,
   output logic            t2_irq,
   output logic            t3_irq
);
   dsct_pkg::dsct_cksel_t cksel_q;
   dsct_pkg::dsct_wr_t    wr2;
   dsct_pkg::dsct_wr_t    wr3;
   dsct_pkg::dsct_ctrl_t  ctrl2;
   dsct_pkg::dsct_ctrl_t  ctrl3;
   logic [7:0]            rl2, rh2, cl2, ch2;
   logic [7:0]            rl3, rh3, cl3, ch3;
   logic [7:0]            rdata_d;
   logic                  pulse_div;
   logic                  pulse_a;
   logic                  pulse_b;
   logic [3:0]            ticks;

   // shared time base; sys/12 and both ticks are one mclk wide
   dsct_pulse #(.PERIOD(dsct_pkg::DIV_SYS)) u_div (
      .mclk  (mclk),
      .srst  (srst),
      .pulse (pulse_div)
   );
   dsct_pulse #(.PERIOD(dsct_pkg::TICK_A_CYCLES)) u_tick_a (
      .mclk  (mclk),
      .srst  (srst),
      .pulse (pulse_a)
   );
   dsct_pulse #(.PERIOD(dsct_pkg::TICK_B_CYCLES)) u_tick_b (
      .mclk  (mclk),
      .srst  (srst),
      .pulse (pulse_b)
   );
   assign ticks = {pulse_b, pulse_a, pulse_div, 1'b1};

   // write decode; each colliding high byte answers only at its alias, the shared address writes the low byte
   assign wr2.ctrl      = sfr_wr && sfr_addr == dsct_pkg::ADDR_T2_CONTROL;
   assign wr2.reload_lo = sfr_wr && sfr_addr == dsct_pkg::ADDR_T2_RELOAD_LOW;
   assign wr2.reload_hi = sfr_wr && sfr_addr == dsct_pkg::ADDR_T2_RELOAD_H_ALT;
   assign wr2.count_lo  = sfr_wr && sfr_addr == dsct_pkg::ADDR_T2_COUNT_LOW;
   assign wr2.count_hi  = sfr_wr && sfr_addr == dsct_pkg::ADDR_T2_COUNT_HIGH;
   assign wr3.ctrl      = sfr_wr && sfr_addr == dsct_pkg::ADDR_T3_CONTROL;
   assign wr3.reload_lo = sfr_wr && sfr_addr == dsct_pkg::ADDR_T3_RELOAD_LOW;
   assign wr3.reload_hi = sfr_wr && sfr_addr == dsct_pkg::ADDR_T3_RELOAD_HIGH;
   assign wr3.count_lo  = sfr_wr && sfr_addr == dsct_pkg::ADDR_T3_COUNT_LOW;
   assign wr3.count_hi  = sfr_wr && sfr_addr == dsct_pkg::ADDR_T3_COUNT_H_ALT;
   wire   wr_cksel      = sfr_wr && sfr_addr == dsct_pkg::ADDR_CLOCK_SELECT;

   // clock select register
   always_ff @(posedge mclk) begin
      if (srst) begin
         cksel_q <= dsct_pkg::dsct_cksel_t'(dsct_pkg::RESET_BYTE);
      end else if (wr_cksel) begin
         cksel_q <= dsct_pkg::dsct_cksel_t'(sfr_wdata);
      end
   end

   dsct_timer u_t2 (
      .mclk       (mclk),
      .srst       (srst),
      .wr         (wr2),
      .wdata      (sfr_wdata),
      .ticks      (ticks),
      .src_lo     (cksel_q.t2_lo),
      .src_hi     (cksel_q.t2_hi),
      .cap_lo_evt (t2_cap_lo_evt),
      .cap_hi_evt (t2_cap_hi_evt),
      .ctrl       (ctrl2),
      .reload_lo  (rl2),
      .reload_hi  (rh2),
      .count_lo   (cl2),
      .count_hi   (ch2),
      .irq        (t2_irq)
   );

   dsct_timer u_t3 (
      .mclk       (mclk),
      .srst       (srst),
      .wr         (wr3),
      .wdata      (sfr_wdata),
      .ticks      (ticks),
      .src_lo     (cksel_q.t3_lo),
      .src_hi     (cksel_q.t3_hi),
      .cap_lo_evt (t3_cap_lo_evt),
      .cap_hi_evt (t3_cap_hi_evt),
      .ctrl       (ctrl3),
      .reload_lo  (rl3),
      .reload_hi  (rh3),
      .count_lo   (cl3),
      .count_hi   (ch3),
      .irq        (t3_irq)
   );

   // read mux; unmapped addresses read zero
   assign rdata_d =
      (sfr_addr == dsct_pkg::ADDR_T2_CONTROL)     ? 8'(ctrl2) :
      (sfr_addr == dsct_pkg::ADDR_CLOCK_SELECT)   ? 8'(cksel_q) :
      (sfr_addr == dsct_pkg::ADDR_T2_RELOAD_LOW)  ? rl2 :
      (sfr_addr == dsct_pkg::ADDR_T2_RELOAD_H_ALT) ? rh2 :
      (sfr_addr == dsct_pkg::ADDR_T2_COUNT_LOW)   ? cl2 :
      (sfr_addr == dsct_pkg::ADDR_T2_COUNT_HIGH)  ? ch2 :
      (sfr_addr == dsct_pkg::ADDR_T3_CONTROL)     ? 8'(ctrl3) :
      (sfr_addr == dsct_pkg::ADDR_T3_RELOAD_LOW)  ? rl3 :
      (sfr_addr == dsct_pkg::ADDR_T3_RELOAD_HIGH) ? rh3 :
      (sfr_addr == dsct_pkg::ADDR_T3_COUNT_LOW)   ? cl3 :
      (sfr_addr == dsct_pkg::ADDR_T3_COUNT_H_ALT) ? ch3 :
      dsct_pkg::RESET_BYTE;

   // read data is registered to keep the core's read path short
   always_ff @(posedge mclk) begin
      if (srst) begin
         sfr_rdata <= dsct_pkg::RESET_BYTE;
      end else begin
         sfr_rdata <= rdata_d;
      end
   end

endmodule : dsct_timers

// *** bench/dsct_core_model.sv ***
// Purpose: behavioural core side of the special-function-register port
// Assumes: every access starts just after a falling edge of mclk
// Notes:   one access per cycle; read data is taken one cycle after the address
`timescale 1ns/1ps
module dsct_core_model (
   input  wire logic       mclk,
   input  wire logic [7:0] sfr_rdata,
   output logic      [7:0] sfr_addr,
   output logic            sfr_wr,
   output logic      [7:0] sfr_wdata
);
   // park on an unmapped address so idle reads stay harmless
   initial begin
      sfr_addr  = 8'hc7;
      sfr_wr    = 1'b0;
      sfr_wdata = 8'h00;
   end

   // time of the last strobe release; a write straight after it waits one edge
   realtime rel_t = -1.0;

   // strobe held across exactly one rising edge; flags are only ever cleared this way
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if ($realtime == rel_t) @(negedge mclk);  // never lower and raise in one step
      sfr_addr  = a;
      sfr_wr    = 1'b1;
      sfr_wdata = d;
      @(negedge mclk);
      sfr_wr    = 1'b0;
      sfr_wdata = ~d;   // stale data is scrambled, not left looking valid
      rel_t     = $realtime;
   endtask : wr

   // address taken at the next rising edge, data settled by the falling one
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr_addr = a;
      @(negedge mclk);
      d = sfr_rdata;
   endtask : rd
endmodule : dsct_core_model

// *** bench/dsct_timers_test.sv ***
// Purpose: self-checking bench for the dual split/capture timers
// Assumes: inputs change at the falling edge; counts run from preset values
// Notes:   capture checks use the divide-by-12 clock so the count sits still
`timescale 1ns/1ps
module dsct_timers_test;
   logic       mclk;
   logic       srst;
   logic [7:0] sfr_addr;
   logic       sfr_wr;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic [3:0] cap;       // t3 hi, t3 lo, t2 hi, t2 lo
   logic       t2_irq;
   logic       t3_irq;
   int         fails;
   int         n_tests;

   dsct_timers dut_u (
      .mclk          (mclk),
      .srst          (srst),
      .sfr_addr      (sfr_addr),
      .sfr_wr        (sfr_wr),
      .sfr_wdata     (sfr_wdata),
      .sfr_rdata     (sfr_rdata),
      .t2_cap_lo_evt (cap[0]),
      .t2_cap_hi_evt (cap[1]),
      .t3_cap_lo_evt (cap[2]),
      .t3_cap_hi_evt (cap[3]),
      .t2_irq        (t2_irq),
      .t3_irq        (t3_irq)
   );

   dsct_core_model core_u (
      .mclk      (mclk),
      .sfr_rdata (sfr_rdata),
      .sfr_addr  (sfr_addr),
      .sfr_wr    (sfr_wr),
      .sfr_wdata (sfr_wdata)
   );

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      core_u.rd(a, d);
      check(d, exp, $sformatf("read %h", a));
   endtask : rdchk

   // start from a preset count, look at flags and irq five edges in, stop on the sixth
   task automatic burst(input logic [7:0] ca, input logic [7:0] run,
                        input logic [7:0] exp_c, input logic exp_i, input logic [7:0] stop);
      logic irq;
      core_u.wr(ca, run);
      repeat (3) @(negedge mclk);
      rdchk(ca, exp_c);
      irq = (ca == dsct_pkg::ADDR_T2_CONTROL) ? t2_irq : t3_irq;
      check({7'h00, irq}, {7'h00, exp_i}, "irq");
      core_u.wr(ca, stop);
   endtask : burst

   // poll a count byte each cycle until it moves; bounded so a dead clock cannot hang us
   // gap counts polls after the first one, so it is one short of the tick period
   task automatic wait_move(input logic [7:0] a, output logic [7:0] v, output int gap,
                            input int lim);
      logic [7:0] prev;
      core_u.rd(a, prev);
      v   = prev;
      gap = 0;
      while (v === prev) begin
         core_u.rd(a, v);
         gap++;
         if (gap > lim) begin
            fails++;
            $display("ERROR %0t count never moved", $time);
            wrap_up();
         end
      end
   endtask : wait_move

   task automatic pulse(input logic [3:0] m);
      cap = m;
      @(negedge mclk);
      cap = 4'h0;
   endtask : pulse

   task automatic t_reset();
      logic [7:0] a [12] = '{dsct_pkg::ADDR_T3_CONTROL, dsct_pkg::ADDR_T3_RELOAD_LOW,
         dsct_pkg::ADDR_T3_RELOAD_HIGH, dsct_pkg::ADDR_T3_COUNT_LOW,
         dsct_pkg::ADDR_T3_COUNT_H_ALT, dsct_pkg::ADDR_T2_CONTROL,
         dsct_pkg::ADDR_CLOCK_SELECT, dsct_pkg::ADDR_T2_RELOAD_LOW,
         dsct_pkg::ADDR_T2_RELOAD_H_ALT, dsct_pkg::ADDR_T2_COUNT_LOW,
         dsct_pkg::ADDR_T2_COUNT_HIGH, 8'hc7};
      core_u.wr(8'hc7, 8'h5a);   // unmapped write must vanish
      foreach (a[i]) rdchk(a[i], 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs();
      logic [7:0] a [9] = '{8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc9};
      foreach (a[i]) core_u.wr(a[i], 8'h21 + 8'(i) * 8'h11);
      foreach (a[i]) rdchk(a[i], 8'h21 + 8'(i) * 8'h11);
      foreach (a[i]) core_u.wr(a[i], 8'h00);
      $display("test regs done");
   endtask : t_regs

   task automatic t_wide_timer();
      core_u.wr(dsct_pkg::ADDR_T2_RELOAD_LOW, 8'hf0);
      core_u.wr(dsct_pkg::ADDR_T2_RELOAD_H_ALT, 8'hff);
      core_u.wr(dsct_pkg::ADDR_T2_COUNT_LOW, 8'hfe);
      core_u.wr(dsct_pkg::ADDR_T2_COUNT_HIGH, 8'hff);
      burst(dsct_pkg::ADDR_T2_CONTROL, 8'h01, 8'hc1, 1'b1, 8'hc0);
      rdchk(dsct_pkg::ADDR_T2_COUNT_LOW, 8'hf3);
      rdchk(dsct_pkg::ADDR_T2_COUNT_HIGH, 8'hff);
      repeat (20) @(negedge mclk);
      rdchk(dsct_pkg::ADDR_T2_CONTROL, 8'hc0);
      core_u.wr(dsct_pkg::ADDR_T2_CONTROL, 8'h00);
      check({7'h00, t2_irq}, 8'h00, "irq cleared");
      // low-byte carry alone: low flag only, irq waits for its enable
      core_u.wr(dsct_pkg::ADDR_T2_COUNT_LOW, 8'hfe);
      core_u.wr(dsct_pkg::ADDR_T2_COUNT_HIGH, 8'h00);
      burst(dsct_pkg::ADDR_T2_CONTROL, 8'h01, 8'h41, 1'b0, 8'h60);
      check({7'h00, t2_irq}, 8'h01, "irq enabled");
      rdchk(dsct_pkg::ADDR_T2_COUNT_LOW, 8'h03);
      rdchk(dsct_pkg::ADDR_T2_COUNT_HIGH, 8'h01);
      // upper run alone means nothing while wide
      core_u.wr(dsct_pkg::ADDR_T2_CONTROL, 8'h02);
      repeat (10) @(negedge mclk);
      rdchk(dsct_pkg::ADDR_T2_COUNT_LOW, 8'h03);
      core_u.wr(dsct_pkg::ADDR_T2_CONTROL, 8'h00);
      $display("test wide timer done");
   endtask : t_wide_timer

   task automatic t_split_timer();
      core_u.wr(dsct_pkg::ADDR_T3_RELOAD_LOW, 8'h80);
      core_u.wr(dsct_pkg::ADDR_T3_RELOAD_HIGH, 8'h20);
      core_u.wr(dsct_pkg::ADDR_T3_COUNT_LOW, 8'hfe);
      core_u.wr(dsct_pkg::ADDR_T3_COUNT_H_ALT, 8'hfe);
      burst(dsct_pkg::ADDR_T3_CONTROL, 8'h11, 8'h51, 1'b0, 8'h10);
      rdchk(dsct_pkg::ADDR_T3_COUNT_LOW, 8'h83);
      rdchk(dsct_pkg::ADDR_T3_COUNT_H_ALT, 8'hfe);
      burst(dsct_pkg::ADDR_T3_CONTROL, 8'h12, 8'h92, 1'b1, 8'h10);
      rdchk(dsct_pkg::ADDR_T3_COUNT_H_ALT, 8'h23);
      rdchk(dsct_pkg::ADDR_T3_COUNT_LOW, 8'h83);
      $display("test split timer done");
   endtask : t_split_timer

   task automatic t_capture();
      logic [7:0] v;
      logic [7:0] wl;
      logic [7:0] wh;
      int         gap;
      core_u.wr(dsct_pkg::ADDR_T2_COUNT_LOW, 8'hfe);
      core_u.wr(dsct_pkg::ADDR_T2_COUNT_HIGH, 8'hff);
      burst(dsct_pkg::ADDR_T2_CONTROL, 8'h05, 8'h45, 1'b0, 8'h04);
      rdchk(dsct_pkg::ADDR_T2_COUNT_LOW, 8'h03);
      rdchk(dsct_pkg::ADDR_T2_COUNT_HIGH, 8'h00);
      // slow clock keeps each count still for eleven edges around a capture
      core_u.wr(dsct_pkg::ADDR_CLOCK_SELECT, 8'h51);
      core_u.wr(dsct_pkg::ADDR_T2_CONTROL, 8'h0d);
      core_u.wr(dsct_pkg::ADDR_T3_CONTROL, 8'h1f);
      wait_move(dsct_pkg::ADDR_T2_COUNT_LOW, v, gap, 40);
      wait_move(dsct_pkg::ADDR_T2_COUNT_LOW, v, gap, 40);
      check(8'(gap), 8'(dsct_pkg::DIV_SYS - 1), "tick gap");
      pulse(4'b0011);
      rdchk(dsct_pkg::ADDR_T2_RELOAD_LOW, v);
      rdchk(dsct_pkg::ADDR_T2_RELOAD_H_ALT, 8'h00);
      rdchk(dsct_pkg::ADDR_T2_CONTROL, 8'h8d);
      check({7'h00, t2_irq}, 8'h01, "t2 irq");
      core_u.rd(dsct_pkg::ADDR_T3_COUNT_LOW, wl);
      core_u.rd(dsct_pkg::ADDR_T3_COUNT_H_ALT, wh);
      pulse(4'b1100);
      rdchk(dsct_pkg::ADDR_T3_RELOAD_LOW, wl);
      rdchk(dsct_pkg::ADDR_T3_RELOAD_HIGH, wh);
      rdchk(dsct_pkg::ADDR_T3_CONTROL, 8'hdf);
      check({7'h00, t3_irq}, 8'h01, "t3 irq");
      // the two slow ticks on the t2 low half; t3 stays on sys/12 meanwhile
      core_u.wr(dsct_pkg::ADDR_CLOCK_SELECT, 8'h52);
      wait_move(dsct_pkg::ADDR_T2_COUNT_LOW, v, gap, 400);
      wait_move(dsct_pkg::ADDR_T2_COUNT_LOW, v, gap, 400);
      check(8'(gap), 8'(dsct_pkg::TICK_A_CYCLES - 1), "tick a gap");
      core_u.wr(dsct_pkg::ADDR_CLOCK_SELECT, 8'h53);
      wait_move(dsct_pkg::ADDR_T2_COUNT_LOW, v, gap, 8000);
      wait_move(dsct_pkg::ADDR_T2_COUNT_LOW, v, gap, 8000);
      check(8'(gap), 8'(dsct_pkg::TICK_B_CYCLES - 1), "tick b gap lo");
      check(8'(gap >> 8), 8'((dsct_pkg::TICK_B_CYCLES - 1) >> 8), "tick b gap hi");
      core_u.wr(dsct_pkg::ADDR_T2_CONTROL, 8'h00);
      core_u.wr(dsct_pkg::ADDR_T3_CONTROL, 8'h00);
      core_u.wr(dsct_pkg::ADDR_CLOCK_SELECT, 8'h00);
      $display("test capture done");
   endtask : t_capture

   // reset for eight cycles, then the scenarios in turn
   initial begin
      srst    = 1'b1;
      cap     = 4'h0;
      fails   = 0;
      n_tests = 0;
      repeat (8) @(negedge mclk);
      srst = 1'b0;
      t_reset();
      t_regs();
      t_wide_timer();
      t_split_timer();
      t_capture();
      wrap_up();
   end
endmodule : dsct_timers_test
